//--- verilog/tpp_consts.vh
// Constants for the period timer and system clock PWM block
`ifndef TPP_CONSTS_VH
`define TPP_CONSTS_VH

`define TPP_ADDR_COUNT      12'h000
`define TPP_ADDR_PERIOD     12'h004
`define TPP_ADDR_CONTROL    12'h008
`define TPP_ADDR_DUTY       12'h00C
`define TPP_ADDR_PHASE      12'h010
`define TPP_ADDR_MODE       12'h014
`define TPP_ADDR_FLAGS      12'h018
`define TPP_ADDR_STATUS     12'h01C

`define TPP_COUNT_RST       8'h00
`define TPP_PERIOD_RST      8'hFF
`define TPP_DUTY_RST        8'h00
`define TPP_PHASE_RST       8'h00
`define TPP_CTRL_RST        3'h0
`define TPP_MODE_RST        2'h0

`define TPP_RUN_BIT         2
`define TPP_PS_HI           1
`define TPP_PS_LO           0
`define TPP_CTRL_MASK       8'h07
`define TPP_FLAG_BIT        0
`define TPP_PSC_RST         4'h0
`define TPP_PSC_STEP        4'h1
`define TPP_COUNT_STEP      8'h01

`define TPP_MODE_ALONE      2'h0
`define TPP_MODE_MASTER     2'h1
`define TPP_MODE_SLAVE      2'h2

`define TPP_PS_DIV1         2'h0
`define TPP_PS_DIV4         2'h1
`define TPP_PS_DIV8         2'h2
`define TPP_PS_DIV16        2'h3
`define TPP_PSC_MAX1        4'h0
`define TPP_PSC_MAX4        4'h3
`define TPP_PSC_MAX8        4'h7
`define TPP_PSC_MAX16       4'hF

`define TPP_PHASE_IDLE      1'b0
`define TPP_PHASE_WAIT      1'b1

`endif

//--- verilog/tpp_timer_pwm.v
// Period timer with prescaler driving the converter system clock PWM
`timescale 1ns/1ns
`include "tpp_consts.vh"

module tpp_timer_pwm (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        sleep,
    input  wire        sync_in,
    output reg         sync_out,
    output reg         sync_oe_n,
    output reg         sys_clock,
    output reg         period_match_flag
);

    reg  [7:0]  timer_count_ff;
    reg  [7:0]  period_value_ff;
    reg  [2:0]  timer_control_ff;
    reg  [7:0]  duty_buffer_ff;
    reg  [7:0]  duty_active_ff;
    reg  [7:0]  phase_buffer_ff;
    reg  [7:0]  phase_active_ff;
    reg  [1:0]  mode_ff;
    reg  [3:0]  psc_ff;
    reg         pwm_ff;
    reg         sync_in_d_ff;
    reg         phase_st_ff;
    reg  [7:0]  phase_cnt_ff;
    reg         slave_clk_ff;

    // Next-state values
    reg  [3:0]  nxt_psc;
    reg  [7:0]  nxt_timer_count;
    reg         nxt_match_flag;
    reg         nxt_pwm;
    reg         nxt_sys_clock;
    reg         nxt_sync_out;
    reg         nxt_sync_oe_n;
    reg  [31:0] nxt_prdata;

    // Write strobe for one register offset
    function reg_hit;
        input        wen;
        input [11:0] addr;
        input [11:0] target;
        begin
            reg_hit = wen && (addr == target);
        end
    endfunction

    wire        wr_en   = psel && penable && pwrite;
    wire        rd_en   = psel && !penable && !pwrite;
    wire        wr_cnt  = reg_hit(wr_en, paddr, `TPP_ADDR_COUNT);
    wire        wr_per  = reg_hit(wr_en, paddr, `TPP_ADDR_PERIOD);
    wire        wr_ctl  = reg_hit(wr_en, paddr, `TPP_ADDR_CONTROL);
    wire        wr_duty = reg_hit(wr_en, paddr, `TPP_ADDR_DUTY);
    wire        wr_phs  = reg_hit(wr_en, paddr, `TPP_ADDR_PHASE);
    wire        wr_mode = reg_hit(wr_en, paddr, `TPP_ADDR_MODE);
    wire        wr_flg  = reg_hit(wr_en, paddr, `TPP_ADDR_FLAGS);
    wire        running = timer_control_ff[`TPP_RUN_BIT] && !sleep;
    wire        is_slave  = (mode_ff == `TPP_MODE_SLAVE);
    wire        is_master = (mode_ff == `TPP_MODE_MASTER);

    // Zero-wait answer, raised once out of reset
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= 1'b1;
            pslverr <= 1'b0;
        end
    end

    // Last prescaler count for a select code
    function [3:0] psc_max;
        input [1:0] sel;
        begin
            case (sel)
                `TPP_PS_DIV1:  psc_max = `TPP_PSC_MAX1;
                `TPP_PS_DIV4:  psc_max = `TPP_PSC_MAX4;
                `TPP_PS_DIV8:  psc_max = `TPP_PSC_MAX8;
                default:       psc_max = `TPP_PSC_MAX16;
            endcase
        end
    endfunction

    wire tick = running && (psc_ff == psc_max(timer_control_ff[`TPP_PS_HI:`TPP_PS_LO]));
    wire match = (timer_count_ff == period_value_ff);
    wire wrap  = tick && match;
    // Slave: rising edge of sync clock ORed with own wrap latches buffers
    wire sync_rise = is_slave && sync_in && !sync_in_d_ff;
    wire latch = wrap || (sync_rise && !sleep);

    // Next prescaler count
    always @*
    begin
        nxt_psc = psc_ff;
        if (wr_cnt || wr_ctl)
            nxt_psc = `TPP_PSC_RST;
        else if (tick)
            nxt_psc = `TPP_PSC_RST;
        else if (running)
            nxt_psc = psc_ff + `TPP_PSC_STEP;
    end

    // Prescaler
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            psc_ff <= `TPP_PSC_RST;
        else
            psc_ff <= nxt_psc;
    end

    // Next count: software write beats wrap, wrap beats increment
    always @*
    begin
        nxt_timer_count = timer_count_ff;
        if (wr_cnt)
            nxt_timer_count = pwdata[7:0];
        else if (wrap)
            nxt_timer_count = `TPP_COUNT_RST;
        else if (tick)
            nxt_timer_count = timer_count_ff + `TPP_COUNT_STEP;
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            timer_count_ff <= `TPP_COUNT_RST;
        else
            timer_count_ff <= nxt_timer_count;
    end

    // Period value
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            period_value_ff <= `TPP_PERIOD_RST;
        else if (wr_per)
            period_value_ff <= pwdata[7:0];
    end

    // Control; count is left alone
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            timer_control_ff <= `TPP_CTRL_RST;
        else if (wr_ctl)
            timer_control_ff <= pwdata[2:0];
    end

    // Duty buffer, writable at any time
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            duty_buffer_ff <= `TPP_DUTY_RST;
        else if (wr_duty)
            duty_buffer_ff <= pwdata[7:0];
    end

    // Phase buffer
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            phase_buffer_ff <= `TPP_PHASE_RST;
        else if (wr_phs)
            phase_buffer_ff <= pwdata[7:0];
    end

    // Sync mode
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mode_ff <= `TPP_MODE_RST;
        else if (wr_mode)
            mode_ff <= pwdata[1:0];
    end

    // Active copies load only on a latch event
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            duty_active_ff  <= `TPP_DUTY_RST;
            phase_active_ff <= `TPP_PHASE_RST;
        end
        else if (latch)
        begin
            duty_active_ff  <= duty_buffer_ff;
            phase_active_ff <= phase_buffer_ff;
        end
    end

    // Match flag: hardware set wins over software clear
    always @*
    begin
        nxt_match_flag = period_match_flag;
        if (wrap)
            nxt_match_flag = 1'b1;
        else if (wr_flg && pwdata[`TPP_FLAG_BIT])
            nxt_match_flag = 1'b0;
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            period_match_flag <= 1'b0;
        else
            period_match_flag <= nxt_match_flag;
    end

    // Own PWM: high from period start until count reaches active duty
    always @*
    begin
        nxt_pwm = pwm_ff;
        if (sleep)
            nxt_pwm = pwm_ff;
        else if (!timer_control_ff[`TPP_RUN_BIT])
            nxt_pwm = 1'b0;
        else if (wrap)
            nxt_pwm = (duty_buffer_ff != `TPP_DUTY_RST);
        else if (tick && (timer_count_ff + `TPP_COUNT_STEP == duty_active_ff))
            nxt_pwm = 1'b0;
        else if (timer_count_ff == duty_active_ff)
            nxt_pwm = 1'b0;
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pwm_ff <= 1'b0;
        else
            pwm_ff <= nxt_pwm;
    end

    // Slave phase placement after master edge
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync_in_d_ff <= 1'b1;
            phase_st_ff  <= `TPP_PHASE_IDLE;
            phase_cnt_ff <= 8'h00;
            slave_clk_ff <= 1'b0;
        end
        else if (!sleep)
        begin
            sync_in_d_ff <= sync_in;
            case (phase_st_ff)
                `TPP_PHASE_IDLE:
                begin
                    if (sync_rise)
                    begin
                        phase_st_ff  <= `TPP_PHASE_WAIT;
                        phase_cnt_ff <= 8'h00;
                        slave_clk_ff <= 1'b0;
                    end
                    else if (tick && phase_cnt_ff + 8'h01 >= duty_active_ff)
                        slave_clk_ff <= 1'b0;
                    else if (tick)
                        phase_cnt_ff <= phase_cnt_ff + 8'h01;
                end
                `TPP_PHASE_WAIT:
                begin
                    if (phase_cnt_ff >= phase_active_ff)
                    begin
                        phase_st_ff  <= `TPP_PHASE_IDLE;
                        phase_cnt_ff <= 8'h00;
                        slave_clk_ff <= (duty_active_ff != 8'h00);
                    end
                    else if (tick)
                        phase_cnt_ff <= phase_cnt_ff + 8'h01;
                end
                default:
                    phase_st_ff <= `TPP_PHASE_IDLE;
            endcase
        end
    end

    // System clock and sync pin hold their level in sleep
    always @*
    begin
        nxt_sys_clock = sys_clock;
        nxt_sync_out  = sync_out;
        nxt_sync_oe_n = sync_oe_n;
        if (!sleep)
        begin
            nxt_sys_clock = is_slave ? (slave_clk_ff | pwm_ff) : pwm_ff;
            nxt_sync_out  = pwm_ff;
            nxt_sync_oe_n = !is_master;
        end
    end

    // System clock and sync pin
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sys_clock <= 1'b0;
            sync_out  <= 1'b0;
            sync_oe_n <= 1'b1;
        end
        else
        begin
            sys_clock <= nxt_sys_clock;
            sync_out  <= nxt_sync_out;
            sync_oe_n <= nxt_sync_oe_n;
        end
    end

    // Read mux; unmapped offsets read zero
    always @*
    begin
        nxt_prdata = prdata;
        if (rd_en)
        begin
            case (paddr)
                `TPP_ADDR_COUNT:   nxt_prdata = {24'h0, timer_count_ff};
                `TPP_ADDR_PERIOD:  nxt_prdata = {24'h0, period_value_ff};
                `TPP_ADDR_CONTROL: nxt_prdata = {29'h0, timer_control_ff};
                `TPP_ADDR_DUTY:    nxt_prdata = {24'h0, duty_buffer_ff};
                `TPP_ADDR_PHASE:   nxt_prdata = {24'h0, phase_buffer_ff};
                `TPP_ADDR_MODE:    nxt_prdata = {30'h0, mode_ff};
                `TPP_ADDR_FLAGS:   nxt_prdata = {31'h0, period_match_flag};
                `TPP_ADDR_STATUS:  nxt_prdata = {16'h0, phase_active_ff, duty_active_ff};
                default:           nxt_prdata = 32'h0000_0000;
            endcase
        end
    end

    // APB read data captured in setup phase, held until the next read
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else
            prdata <= nxt_prdata;
    end

endmodule // tpp_timer_pwm

//--- verif/tpp_timer_pwm_chk.sv
// Port assertions for the period timer PWM block
`timescale 1ns/1ns
`include "tpp_consts.vh"
module tpp_timer_pwm_chk (
    input wire        pclk, presetn, psel, penable, pwrite, pready, pslverr,
    input wire [11:0] paddr,
    input wire [31:0] pwdata, prdata,
    input wire        sleep, sync_in, sync_out, sync_oe_n, sys_clock, period_match_flag
);
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    wire rd = psel & ~penable & ~pwrite;
    wire wr = psel & penable & pwrite;
    wire wm = wr & (paddr == `TPP_ADDR_MODE);
    wire fc = wr & (paddr == `TPP_ADDR_FLAGS) & pwdata[0];
    property p_rdy; psel & penable |-> pready; endproperty
    a_rdy: assert property (p_rdy) else $error("access not answered");
    property p_unm; rd && paddr > `TPP_ADDR_STATUS |=> prdata == 32'h0; endproperty
    a_unm: assert property (p_unm) else $error("unmapped read not zero");
    property p_hi; rd && paddr != `TPP_ADDR_STATUS |=> prdata[31:8] == 24'h0; endproperty
    a_hi: assert property (p_hi) else $error("byte register upper bits set");
    property p_ctl; rd && paddr == `TPP_ADDR_CONTROL |=> prdata[31:3] == 29'h0; endproperty
    a_ctl: assert property (p_ctl) else $error("control unused bits set");
    property p_hold; !rd |=> $stable(prdata); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_flag; period_match_flag && !fc |=> period_match_flag; endproperty
    a_flag: assert property (p_flag) else $error("match flag lost");
    property p_slp; sleep |=> $stable(sys_clock) && $stable(sync_out); endproperty
    a_slp: assert property (p_slp) else $error("output moved in sleep");
    property p_oe; !wm && !$past(wm) |=> $stable(sync_oe_n); endproperty
    a_oe: assert property (p_oe) else $error("sync enable moved");
endmodule // tpp_timer_pwm_chk

bind tpp_timer_pwm tpp_timer_pwm_chk chk_u (.*);

//--- verif/tpp_sync_master.sv
// Far-side converter driving its master clock onto the sync pin
`timescale 1ns/1ns
module tpp_sync_master (
    input  wire logic clk,
    input  wire logic en,
    output wire logic sync_o
);
    logic [3:0] ph_ff = 4'h0;
    logic       s_ff  = 1'b1;
    assign sync_o = s_ff;
    // Idle line rests at its pull-up level
    always @(posedge clk)
    begin
        ph_ff <= en ? ph_ff + 4'h1 : 4'h0;
        s_ff  <= en ? ph_ff[3] : 1'b1;
    end
endmodule // tpp_sync_master

//--- verif/tb.sv
// Self-checking bench for the period timer PWM block
`timescale 1ns/1ns
`include "tpp_consts.vh"
module tb;
    logic        pclk, presetn, psel, penable, pwrite, sleep, sen;
    logic [11:0] paddr;
    logic [31:0] pwdata, d;
    logic [7:0]  r8, pv, dv, d2;
    wire  [31:0] prdata;
    wire         pready, pslverr, sync_in, sync_out, sync_oe_n, sys_clock, period_match_flag;
    int          fail_count = 0;
    int          n_tests = 0;
    int          h, p, i;

    tpp_timer_pwm dut_u (.*);
    tpp_sync_master peer_u (.clk(pclk), .en(sen), .sync_o(sync_in));

    function logic [7:0] lf(input logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction
    function int nd(input int s);
        return s == 0 ? 1 : s == 1 ? 4 : s == 2 ? 8 : 16;
    endfunction
    task chk(input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e)
        begin
            fail_count++;
            $display("wrong value at %0t: got %h want %h", $time, s, e);
        end
    endtask
    task rw(input logic w, input logic [11:0] a, input logic [31:0] v);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= v;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        d = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // High and full period in clocks, from one rise to the next
    task meas;
        h = 0;
        while (sys_clock === 1'b1) @(posedge pclk);
        while (sys_clock !== 1'b1) @(posedge pclk);
        while (sys_clock === 1'b1)
        begin
            @(posedge pclk);
            h++;
        end
        p = h;
        while (sys_clock !== 1'b1)
        begin
            @(posedge pclk);
            p++;
        end
    endtask
    task summarize;
        if (fail_count == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial
    begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    initial
    begin
        #1000000;
        fail_count++;
        summarize;
    end
    initial
    begin
        {presetn, psel, penable, pwrite, sleep, sen} = 6'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        r8 = 8'h04;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rw(0, `TPP_ADDR_COUNT, 0);
        chk(d, 32'h00);
        rw(0, `TPP_ADDR_PERIOD, 0);
        chk(d, 32'hFF);
        rw(0, 12'h020, 0);
        chk(d, 32'h00);
        for (i = 0; i < 4; i++)
        begin
            r8 = lf(r8);
            pv = {5'h0, r8[2:0]} + 8'h4;
            dv = r8[7:4] % pv + 8'h1;
            rw(1, `TPP_ADDR_PERIOD, {24'h0, pv});
            rw(1, `TPP_ADDR_DUTY, {24'h0, dv});
            rw(1, `TPP_ADDR_CONTROL, 32'h4 | i);
            meas;
            meas;
            chk(h, dv * nd(i));
            chk(p, (pv + 1) * nd(i));
            chk(period_match_flag, 1'b1);
        end
        d2 = (dv == 8'h1) ? 8'h2 : 8'h1;
        rw(1, `TPP_ADDR_DUTY, {24'h0, d2});
        rw(0, `TPP_ADDR_STATUS, 0);
        chk(d[7:0], dv);
        meas;
        rw(0, `TPP_ADDR_STATUS, 0);
        chk(d[7:0], d2);
        r8 = lf(r8);
        rw(1, `TPP_ADDR_CONTROL, 32'h1);
        rw(1, `TPP_ADDR_COUNT, {24'h0, r8});
        rw(1, `TPP_ADDR_CONTROL, 32'h3);
        rw(0, `TPP_ADDR_COUNT, 0);
        chk(d, {24'h0, r8});
        rw(1, `TPP_ADDR_FLAGS, 32'h1);
        rw(0, `TPP_ADDR_FLAGS, 0);
        chk(d, 32'h0);
        rw(1, `TPP_ADDR_CONTROL, 32'hFF);
        rw(0, `TPP_ADDR_CONTROL, 0);
        chk(d, 32'h7);
        sleep <= 1'b1;
        rw(0, `TPP_ADDR_COUNT, 0);
        pv = d[7:0];
        repeat (40) @(posedge pclk);
        rw(0, `TPP_ADDR_COUNT, 0);
        chk(d[7:0], pv);
        sleep <= 1'b0;
        rw(1, `TPP_ADDR_MODE, {30'h0, `TPP_MODE_MASTER});
        repeat (3) @(posedge pclk);
        chk(sync_oe_n, 1'b0);
        repeat (200)
        begin
            @(posedge pclk);
            chk(sync_out, sys_clock);
        end
        rw(1, `TPP_ADDR_CONTROL, 32'h0);
        r8 = lf(r8);
        rw(1, `TPP_ADDR_PHASE, {24'h0, r8});
        rw(1, `TPP_ADDR_MODE, {30'h0, `TPP_MODE_SLAVE});
        sen <= 1'b1;
        repeat (24) @(posedge pclk);
        rw(0, `TPP_ADDR_STATUS, 0);
        chk(d[15:0], {r8, d2});
        summarize;
    end
endmodule // tb
